/* bench/sat_cpu_model.sv */
// Processor model issuing memory reads and I/O port writes.
// Assumes the bench calls its tasks one request at a time.
`timescale 1ns/1ps
module sat_cpu_model
  import sat_pkg::*;
(
  input wire logic clk_sys,
  output logic [CPU_AW-1:0] cpuAddr,
  output logic memReq,
  output logic ioWrite,
  output logic [RELOC_W-1:0] ioData
);
  initial begin
    cpuAddr = 16'h0000;
    memReq = 1'b0;
    ioWrite = 1'b0;
    ioData = 8'h00;
  end
  // Released lines show inverted values so a stale copy cannot pass
  task automatic ioWr(input logic [7:0] port, input logic [7:0] d);
    @(posedge clk_sys);
    cpuAddr <= {8'h00, port};
    ioData <= d;
    ioWrite <= 1'b1;
    @(posedge clk_sys);
    ioWrite <= 1'b0;
    cpuAddr <= ~{8'h00, port};
    ioData <= ~d;
  endtask
  // Port write directly followed by a window access, no gap cycle between
  task automatic ioWrMem(input logic [7:0] port, input logic [7:0] d, input logic [15:0] a);
    @(posedge clk_sys);
    cpuAddr <= {8'h00, port};
    ioData <= d;
    ioWrite <= 1'b1;
    @(posedge clk_sys);
    ioWrite <= 1'b0;
    ioData <= ~d;
    cpuAddr <= a;
    memReq <= 1'b1;
    @(posedge clk_sys);
    memReq <= 1'b0;
    cpuAddr <= ~a;
  endtask
  // Single data accesses only, nothing runs past the window end
  task automatic memRd(input logic [15:0] a);
    @(posedge clk_sys);
    cpuAddr <= a;
    memReq <= 1'b1;
    @(posedge clk_sys);
    memReq <= 1'b0;
    cpuAddr <= ~a;
  endtask
endmodule

/* bench/sat_top_tb.sv */
// Self-checking bench for the segment address translator.
// Assumes the default port base; runs with the window jumpered at A000 and, in one section, at 0000.
`timescale 1ns/1ps
module sat_top_tb
  import sat_pkg::*;
;
  logic clk_sys;
  logic arst_n;
  logic clkEn;
  logic [2:0] windowBaseJumper;
  logic [15:0] cpuAddr;
  logic memReq;
  logic ioWrite;
  logic [7:0] ioData;
  logic [23:0] busAddr;
  logic busValid;
  logic [3:0] ledExt_n;
  int nErrors = 0;
  int testsRun = 0;
  // ----------------------------------------
  // Rows: port, data, access address, expected bus address
  // ----------------------------------------
  logic [55:0] rows [10] = '{56'h00_00_A555_00A555, 56'h00_00_BABC_00BABC,
    56'h82_49_A123_049123, 56'h83_AC_B7FF_0AC7FF, 56'h00_00_1234_001234,
    56'h00_00_9FFF_009FFF, 56'h00_00_C000_00C000, 56'h81_FF_AFFF_049FFF,
    56'h84_FF_B000_0AC000, 56'h83_F3_BFFF_0F3FFF};
  sat_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .cpuAddr(cpuAddr),
    .memReq(memReq), .ioWrite(ioWrite), .ioData(ioData),
    .windowBaseJumper(windowBaseJumper), .busAddr(busAddr), .busValid(busValid),
    .ledExt_n(ledExt_n));
  sat_cpu_model u_cpu (.clk_sys(clk_sys), .cpuAddr(cpuAddr), .memReq(memReq),
    .ioWrite(ioWrite), .ioData(ioData));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic [23:0] e);
    u_cpu.memRd(a);
    #1;
    chk(busAddr, e);
    chk({20'h0, ledExt_n}, {20'h0, ~e[19:16]});
    chk({23'h0, busValid}, 24'h1);
  endtask
  task automatic give_verdict();
    if (nErrors == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    nErrors++;
    give_verdict();
  end
  initial begin
    clkEn = 1'b1;
    arst_n = 1'b0;
    windowBaseJumper = 3'h5;
    repeat (20) @(posedge clk_sys);
    chk(busAddr, 24'h000000);
    chk({20'h0, ledExt_n}, 24'h00000F);
    chk({23'h0, busValid}, 24'h0);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[i]) begin
      u_cpu.ioWr(rows[i][55:48], rows[i][47:40]);
      acc(rows[i][39:24], rows[i][23:0]);
    end
    // Idle cycle drops the valid flag but keeps the address
    @(posedge clk_sys);
    #1;
    chk({23'h0, busValid}, 24'h0);
    chk(busAddr, 24'h0F3FFF);
    // Frozen clock enable must ignore a request
    clkEn <= 1'b0;
    u_cpu.memRd(16'h1234);
    #1;
    chk(busAddr, 24'h0F3FFF);
    chk({23'h0, busValid}, 24'h0);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    windowBaseJumper <= 3'h0;
    repeat (3) @(posedge clk_sys);
    acc(16'h0123, 24'h049123);
    acc(16'h1FFF, 24'h0F3FFF);
    acc(16'hA123, 24'h00A123);
    // Write then access in the very next cycle must see the new value
    u_cpu.ioWrMem(8'h83, 8'h5A, 16'h1000);
    #1;
    chk(busAddr, 24'h05A000);
    chk({23'h0, busValid}, 24'h1);
    // Second reset mid-run restores identity mapping
    @(posedge clk_sys);
    arst_n <= 1'b0;
    windowBaseJumper <= 3'h5;
    @(posedge clk_sys);
    chk(busAddr, 24'h000000);
    chk({20'h0, ledExt_n}, 24'h00000F);
    chk({23'h0, busValid}, 24'h0);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    acc(16'hA123, 24'h00A123);
    give_verdict();
  end
endmodule

/* src/sat_pkg.sv */
// Constants for the segment address translator.
// Assumes an 8-bit processor with 16-bit addresses and 8-bit I/O ports.
package sat_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int CPU_AW = 16;
  localparam int BUS_AW = 24;
  localparam int RELOC_W = 8;
  localparam int PORT_W = 8;
  localparam int OFS_W = 12;
  localparam int LED_W = 4;
  localparam int WIN_TAG_W = 3;
  // ----------------------------------------
  // Register map and defaults
  // ----------------------------------------
  localparam logic [PORT_W-1:0] PORT_BASE_DEFAULT = 8'h80;
  localparam logic [PORT_W-1:0] LOWER_HALF_RELOCATION_OFS = 8'h02;
  localparam logic [PORT_W-1:0] UPPER_HALF_RELOCATION_OFS = 8'h03;
  localparam logic [WIN_TAG_W-1:0] WIN_TAG_DEFAULT = 3'h5;
  localparam logic [RELOC_W-1:0] LOWER_RELOC_RESET = 8'h0A;
  localparam logic [RELOC_W-1:0] UPPER_RELOC_RESET = 8'h0B;
  localparam logic [RELOC_W-1:0] EXT_ZERO = 8'h00;
  localparam logic [3:0] TOP_ZERO = 4'h0;
endpackage

/* src/sat_reloc_regs.sv */
// Two write-only relocation registers loaded from processor I/O writes.
// Assumes write strobes are synchronous one-cycle pulses on clk_sys.
`timescale 1ns/1ps
module sat_reloc_regs
  import sat_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic ioWrite,
  input wire logic [PORT_W-1:0] ioPort,
  input wire logic [RELOC_W-1:0] ioData,
  input wire logic [PORT_W-1:0] portBase,
  output logic [RELOC_W-1:0] lowerReloc,
  output logic [RELOC_W-1:0] upperReloc
);
  logic [RELOC_W-1:0] next_lowerReloc;
  logic [RELOC_W-1:0] next_upperReloc;
  logic [PORT_W-1:0] lowerPort;
  logic [PORT_W-1:0] upperPort;

  assign lowerPort = PORT_W'(portBase + LOWER_HALF_RELOCATION_OFS);
  assign upperPort = PORT_W'(portBase + UPPER_HALF_RELOCATION_OFS);

  always_comb begin
    next_lowerReloc = lowerReloc;
    next_upperReloc = upperReloc;
    if (ioWrite && ioPort == lowerPort) begin
      next_lowerReloc = ioData;
    end
    if (ioWrite && ioPort == upperPort) begin
      next_upperReloc = ioData;
    end
  end

  // Reset to the identity map for the default A000 window so it acts as plain memory
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lowerReloc <= LOWER_RELOC_RESET;
      upperReloc <= UPPER_RELOC_RESET;
    end else if (clkEn) begin
      lowerReloc <= next_lowerReloc;
      upperReloc <= next_upperReloc;
    end
  end
endmodule

/* src/sat_strap_sync.sv */
// Two-stage synchroniser for the static window-base jumper inputs.
// Assumes the jumpers change only while the system is idle.
`timescale 1ns/1ps
module sat_strap_sync #(
  parameter int W = 3
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else if (clkEn) begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule

/* src/sat_top.sv */
// Segment address translator: maps a jumpered 8 KB processor window
// onto the first megabyte of a 24-bit system bus.
// Assumes the processor presents address and strobes synchronous to clk_sys.
`timescale 1ns/1ps
module sat_top
  import sat_pkg::*;
#(
  parameter logic [PORT_W-1:0] PORT_BASE = PORT_BASE_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [CPU_AW-1:0] cpuAddr,
  input wire logic memReq,
  input wire logic ioWrite,
  input wire logic [RELOC_W-1:0] ioData,
  input wire logic [WIN_TAG_W-1:0] windowBaseJumper,
  output logic [BUS_AW-1:0] busAddr,
  output logic busValid,
  output logic [LED_W-1:0] ledExt_n
);
  // ----------------------------------------
  // Window base and relocation registers
  // ----------------------------------------
  logic [WIN_TAG_W-1:0] windowBaseSync;
  logic [RELOC_W-1:0] lowerReloc;
  logic [RELOC_W-1:0] upperReloc;

  // Jumpers come from pins, so they are synchronised before use
  sat_strap_sync #(.W(WIN_TAG_W)) uStrap (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .din(windowBaseJumper),
    .dout(windowBaseSync)
  );

  sat_reloc_regs uRegs (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .ioWrite(ioWrite),
    .ioPort(cpuAddr[PORT_W-1:0]),
    .ioData(ioData),
    .portBase(PORT_BASE),
    .lowerReloc(lowerReloc),
    .upperReloc(upperReloc)
  );

  // ----------------------------------------
  // Translation
  // ----------------------------------------
  logic inWindow;
  logic upperHalf;
  logic [RELOC_W-1:0] selReloc;
  logic [BUS_AW-1:0] next_busAddr;
  logic next_busValid;
  logic [LED_W-1:0] next_ledExt_n;

  // Window tag is the top three address bits, so it aligns to 8 KB
  assign inWindow = cpuAddr[CPU_AW-1 -: WIN_TAG_W] == windowBaseSync;
  assign upperHalf = cpuAddr[OFS_W];
  // Registers are read live, so a write lands before the next access
  assign selReloc = upperHalf ? upperReloc : lowerReloc;

  always_comb begin
    next_busValid = memReq;
    next_busAddr = busAddr;
    if (memReq) begin
      if (inWindow) begin
        next_busAddr = {TOP_ZERO, selReloc, cpuAddr[OFS_W-1:0]};
      end else begin
        next_busAddr = {EXT_ZERO, cpuAddr};
      end
    end
    next_ledExt_n = ~next_busAddr[19:16];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busAddr <= '0;
      busValid <= 1'b0;
      ledExt_n <= '1;
    end else if (clkEn) begin
      busAddr <= next_busAddr;
      busValid <= next_busValid;
      ledExt_n <= next_ledExt_n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_TOP_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    busAddr[23:20] == TOP_ZERO)
    else $error("top bus address bits not zero");

  AST_LED_INV: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ledExt_n == ~busAddr[19:16])
    else $error("indicators not inverse of bus bits");

  AST_WIN_MAP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clkEn && memReq && inWindow |=> busAddr[19:12] == $past(selReloc))
    else $error("window access not relocated");

  AST_LOW_PASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clkEn && memReq |=> busAddr[11:0] == $past(cpuAddr[11:0]))
    else $error("low address bits altered");

  AST_OUT_PASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clkEn && memReq && !inWindow |=> busAddr == {EXT_ZERO, $past(cpuAddr)})
    else $error("outside access not passed through");

  AST_HALF_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clkEn && memReq && inWindow && cpuAddr[OFS_W]
      |=> busAddr[19:12] == $past(upperReloc))
    else $error("upper half used wrong register");

  AST_WRITE_EFFECT: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clkEn && ioWrite && cpuAddr[7:0] == PORT_W'(PORT_BASE + LOWER_HALF_RELOCATION_OFS)
      |=> lowerReloc == $past(ioData))
    else $error("lower relocation write lost");

  AST_NEXT_ACCESS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clkEn && ioWrite && cpuAddr[7:0] == PORT_W'(PORT_BASE + UPPER_HALF_RELOCATION_OFS)
      ##1 clkEn && memReq && inWindow && cpuAddr[OFS_W]
      |=> busAddr[19:12] == $past(ioData, 2))
    else $error("new relocation value not applied");

  AST_VALID: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clkEn |=> busValid == $past(memReq))
    else $error("bus valid does not follow request");
endmodule
